//--- hdl/sdcl_pkg.sv
// Shared constants for the serial delay code loader, both ends
package sdcl_pkg;

    // System clock
    localparam int SYS_CLK_PERIOD_NS = 5;

    // Delay code layout
    localparam int CODE_W = 8;
    localparam int CODE_MAX = 255;
    localparam logic [7:0] CODE_RESET = 8'h00;
    localparam logic [7:0] SHIFT_RESET = 8'h00;

    // Settling time after enable falls, then cycles (longest, rounded down)
    localparam int CODE_SETTLE_TIME_US = 50;
    localparam int CODE_SETTLE_CYCLES = (CODE_SETTLE_TIME_US * 1000) / SYS_CLK_PERIOD_NS;

    // Code zero delay in ns, then in cycles of tap (least, rounded up)
    localparam int MINIMUM_CODE_DELAY_NS = 20;
    localparam int MINIMUM_CODE_TAPS =
        (MINIMUM_CODE_DELAY_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int CODE_STEP_TAPS = 1;

    // Host link timing, least times rounded up
    localparam int LINK_HALF_NS = 60;
    localparam int LINK_HALF_CYCLES = (LINK_HALF_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int ENABLE_LEAD_NS = 80;
    localparam int ENABLE_LEAD_CYCLES =
        (ENABLE_LEAD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int ENABLE_GAP_NS = 50;
    localparam int ENABLE_GAP_CYCLES = (ENABLE_GAP_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

    // Level seen on the serial output line while nobody drives it
    localparam logic Q_IDLE_LEVEL = 1'b1;

endpackage : sdcl_pkg

//--- hdl/sdcl_if.sv
// Four-wire link between controller and delay element
`timescale 1ns/1ps
`default_nettype none
interface sdcl_if;
    logic enable;
    logic sclk;
    logic sdi;
    logic sdo;
    logic sdoEn;
    logic qLine;

    // Resolved serial output line, pulled up while released
    assign qLine = sdoEn ? sdo : sdcl_pkg::Q_IDLE_LEVEL;

    modport device (
        input enable,
        input sclk,
        input sdi,
        output sdo,
        output sdoEn
    );

    modport host (
        output enable,
        output sclk,
        output sdi,
        input qLine
    );
endinterface : sdcl_if
`default_nettype wire

//--- hdl/sdcl_device.sv
// Delay element end: serial code loader and digital tap delay
//
// Contract
// - Hold 8-bit code selecting 256 delays
// - Enable high: each clock shifts one bit
// - Controller sends code MSB first
// - Enable falling commits shifted code as active
// - New delay trusted only after settling
// - Serial output shows bit leaving register
// - Readback recirculates output onto input
// - Unreturned readback shifts input in, destructive
// - Controller shifts eight bits per device
// - Old bits move on to next device
// - Delay may exceed one input period
// - Code zero shortest, equal steps upward
// - Output driven only while enable high
`timescale 1ns/1ps
`default_nettype none
module sdcl_device #(
    parameter int SETTLE_CYCLES = sdcl_pkg::CODE_SETTLE_CYCLES,
    parameter int MIN_TAPS = sdcl_pkg::MINIMUM_CODE_TAPS,
    parameter int STEP_TAPS = sdcl_pkg::CODE_STEP_TAPS
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    sdcl_if.device link,
    input wire logic delayIn,
    output logic delayOut,
    output logic [sdcl_pkg::CODE_W-1:0] activeCode,
    output logic codeSettled
);

    // Depth of the tap line covers the longest code
    localparam int HIST_W = MIN_TAPS + sdcl_pkg::CODE_MAX * STEP_TAPS + 1;
    localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);

    typedef struct packed {
        logic enMeta;
        logic enSync;
        logic enPrev;
        logic clkMeta;
        logic clkSync;
        logic clkPrev;
        logic datMeta;
        logic datSync;
        logic inMeta;
        logic inSync;
        logic [sdcl_pkg::CODE_W-1:0] shift;
        logic [sdcl_pkg::CODE_W-1:0] code;
        logic qOut;
        logic qEn;
        logic [CNT_W-1:0] settleCnt;
        logic settled;
        logic [HIST_W-1:0] hist;
        logic delayOut;
    } sdcl_dev_state_t;

    sdcl_dev_state_t state_r;
    sdcl_dev_state_t state_nxt;

    logic clkRise;
    logic enFall;
    int tapIndex;

    // Edge finding on second synchroniser stages only
    assign clkRise = state_r.clkSync && !state_r.clkPrev;
    assign enFall = !state_r.enSync && state_r.enPrev;

    // Tap chosen by code, equal steps from the minimum
    assign tapIndex = MIN_TAPS + int'(state_r.code) * STEP_TAPS;

    // Next state
    always_comb begin
        state_nxt = state_r;

        // Two-stage synchronisers for every link pin and the delay input
        state_nxt.enMeta = link.enable;
        state_nxt.enSync = state_r.enMeta;
        state_nxt.enPrev = state_r.enSync;
        state_nxt.clkMeta = link.sclk;
        state_nxt.clkSync = state_r.clkMeta;
        state_nxt.clkPrev = state_r.clkSync;
        state_nxt.datMeta = link.sdi;
        state_nxt.datSync = state_r.datMeta;
        state_nxt.inMeta = delayIn;
        state_nxt.inSync = state_r.inMeta;

        // Shift one bit in per clock edge, only while enabled
        if (state_r.enSync && clkRise) begin
            // Incoming bits land at the bottom, so the first bit ends as MSB
            state_nxt.shift = {state_r.shift[sdcl_pkg::CODE_W-2:0], state_r.datSync};
            // Whatever sits on the input is taken, returned or not
        end

        // Serial output is the register's top bit, pushed to the next device
        state_nxt.qOut = state_nxt.shift[sdcl_pkg::CODE_W-1];

        // Output enable follows the synchronised enable
        state_nxt.qEn = state_r.enSync;

        // Commit on enable falling; the code is untouched otherwise
        if (enFall) begin
            state_nxt.code = state_r.shift;
            state_nxt.settleCnt = '0;
            state_nxt.settled = 1'b0;
        end else if (!state_r.settled) begin
            // Count out the settling time
            if (state_r.settleCnt == SETTLE_LAST) begin
                state_nxt.settled = 1'b1;
            end else begin
                state_nxt.settleCnt = state_r.settleCnt + CNT_W'(1);
            end
        end

        // Tap line: input history, one tap per cycle
        state_nxt.hist = {state_r.hist[HIST_W-2:0], state_r.inSync};

        // Delayed output picked from the tap of the active code
        state_nxt.delayOut = state_r.hist[tapIndex];
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_r <= '0;
            state_r.shift <= sdcl_pkg::SHIFT_RESET;
            state_r.code <= sdcl_pkg::CODE_RESET;
            state_r.settled <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Outputs, all from flip-flops
    assign link.sdo = state_r.qOut;
    assign link.sdoEn = state_r.qEn;
    assign activeCode = state_r.code;
    assign codeSettled = state_r.settled;
    assign delayOut = state_r.delayOut;

    // Note: chain length is the controller's business; this end only shifts

endmodule : sdcl_device
`default_nettype wire

//--- hdl/sdcl_host.sv
// Controller end: drives enable, serial clock and data for a device chain
`timescale 1ns/1ps
`default_nettype none
module sdcl_host #(
    parameter int DEVICES = 1,
    parameter int HALF_CYCLES = sdcl_pkg::LINK_HALF_CYCLES,
    parameter int LEAD_CYCLES = sdcl_pkg::ENABLE_LEAD_CYCLES,
    parameter int GAP_CYCLES = sdcl_pkg::ENABLE_GAP_CYCLES
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    sdcl_if.host link,
    input wire logic cmdStart,
    input wire logic cmdReadBack,
    input wire logic [DEVICES*sdcl_pkg::CODE_W-1:0] cmdData,
    output logic cmdReady,
    output logic cmdDone,
    output logic [DEVICES*sdcl_pkg::CODE_W-1:0] rdData
);

    localparam int BITS = DEVICES * sdcl_pkg::CODE_W;
    localparam int BIT_W = $clog2(BITS + 1);
    localparam int CNT_W = 8;
    localparam logic [BIT_W-1:0] BIT_LAST = BIT_W'(BITS - 1);
    localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYCLES - 1);
    localparam logic [CNT_W-1:0] LEAD_LAST = CNT_W'(LEAD_CYCLES - 1);
    localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(GAP_CYCLES - 1);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LEAD = 3'b001,
        ST_LOW = 3'b010,
        ST_HIGH = 3'b011,
        ST_GAP = 3'b100
    } sdcl_host_st_t;

    typedef struct packed {
        sdcl_host_st_t st;
        logic [CNT_W-1:0] cnt;
        logic [BIT_W-1:0] bitCnt;
        logic readBack;
        logic [BITS-1:0] tx;
        logic [BITS-1:0] rx;
        logic enable;
        logic sclk;
        logic sdi;
        logic done;
    } sdcl_host_state_t;

    sdcl_host_state_t state_r;
    sdcl_host_state_t state_nxt;

    // Next state
    always_comb begin
        state_nxt = state_r;
        state_nxt.done = 1'b0;
        state_nxt.cnt = state_r.cnt + CNT_W'(1);
        unique case (state_r.st)
            ST_IDLE: begin
                state_nxt.cnt = '0;
                if (cmdStart) begin
                    state_nxt.st = ST_LEAD;
                    state_nxt.enable = 1'b1;
                    state_nxt.readBack = cmdReadBack;
                    state_nxt.tx = cmdData;
                    state_nxt.bitCnt = '0;
                end
            end
            ST_LEAD: begin
                // Let the serial output become valid before the first bit
                if (state_r.cnt == LEAD_LAST) begin
                    state_nxt.st = ST_LOW;
                    state_nxt.cnt = HALF_LAST;
                end
            end
            ST_LOW: begin
                // Present the bit at the start of the low phase
                if (state_r.cnt == HALF_LAST) begin
                    state_nxt.cnt = '0;
                    state_nxt.rx = {state_r.rx[BITS-2:0], link.qLine};
                    if (state_r.readBack) begin
                        state_nxt.sdi = link.qLine;
                    end else begin
                        state_nxt.sdi = state_r.tx[BITS-1];
                    end
                    state_nxt.tx = {state_r.tx[BITS-2:0], 1'b0};
                end else if (state_r.cnt == HALF_LAST - CNT_W'(1)) begin
                    // High phase counts from zero, so the clock stays high a full half
                    state_nxt.st = ST_HIGH;
                    state_nxt.cnt = '0;
                    state_nxt.sclk = 1'b1;
                end
            end
            ST_HIGH: begin
                if (state_r.cnt == HALF_LAST) begin
                    state_nxt.sclk = 1'b0;
                    state_nxt.cnt = '0;
                    if (state_r.bitCnt == BIT_LAST) begin
                        state_nxt.st = ST_GAP;
                    end else begin
                        state_nxt.st = ST_LOW;
                        state_nxt.cnt = HALF_LAST;
                        state_nxt.bitCnt = state_r.bitCnt + BIT_W'(1);
                    end
                end
            end
            ST_GAP: begin
                // Hold enable past the last fall, then drop it to commit
                if (state_r.enable && state_r.cnt == HALF_LAST) begin
                    state_nxt.enable = 1'b0;
                    state_nxt.cnt = '0;
                end else if (!state_r.enable && state_r.cnt == GAP_LAST) begin
                    state_nxt.st = ST_IDLE;
                    state_nxt.done = 1'b1;
                end
            end
            default: begin
                state_nxt.st = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_r <= '0;
            state_r.st <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Outputs
    assign cmdReady = (state_r.st == ST_IDLE);
    assign cmdDone = state_r.done;
    assign rdData = state_r.rx;
    assign link.enable = state_r.enable;
    assign link.sclk = state_r.sclk;
    assign link.sdi = state_r.sdi;

endmodule : sdcl_host
`default_nettype wire

//--- test/sdcl_check_sva.sv
// Link protocol checks for the serial delay code loader
`timescale 1ns/1ps
`default_nettype none
module sdcl_check_sva (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic enable,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdoEn
);
    logic sclkQ_r;
    logic [7:0] bitCnt_r;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Clock rises counted per frame
    always_ff @(posedge sys_clk) begin
        sclkQ_r <= sclk;
        if (sys_rst || !enable) bitCnt_r <= 8'h00;
        else if (sclk && !sclkQ_r) bitCnt_r <= bitCnt_r + 8'h01;
    end
    property p_fall_low;
        $fell(enable) |-> !sclk;
    endproperty
    a_fall_low: assert property (p_fall_low) else $error("enable fell, clock high");
    property p_whole;
        $fell(enable) |-> bitCnt_r != 8'h00 && bitCnt_r[2:0] == 3'h0;
    endproperty
    a_whole: assert property (p_whole) else $error("frame not whole bytes");
    property p_sdi_hold;
        sclk && $past(sclk) |-> $stable(sdi);
    endproperty
    a_sdi_hold: assert property (p_sdi_hold) else $error("data moved, clock high");
    property p_clk_frame;
        $changed(sclk) |-> enable;
    endproperty
    a_clk_frame: assert property (p_clk_frame) else $error("clock outside frame");
    property p_q_on;
        $rose(enable) |-> ##[1:4] sdoEn;
    endproperty
    a_q_on: assert property (p_q_on) else $error("output not driven");
    property p_q_off;
        $fell(enable) |-> ##[1:4] !sdoEn;
    endproperty
    a_q_off: assert property (p_q_off) else $error("output not released");
    property p_q_idle;
        (!enable) [*5] |-> !sdoEn;
    endproperty
    a_q_idle: assert property (p_q_idle) else $error("output driven idle");
    property p_q_frozen;
        $changed(sdo) |-> $past(enable, 3) || $past(enable, 4);
    endproperty
    a_q_frozen: assert property (p_q_frozen) else $error("shift while disabled");
    property p_q_clk;
        $changed(sdo) |-> $past(sclk, 2) || $past(sclk, 3);
    endproperty
    a_q_clk: assert property (p_q_clk) else $error("output moved unclocked");
endmodule : sdcl_check_sva
`default_nettype wire

//--- test/tb_top.sv
// Bench: host and delay element on one link, raw driver on a second
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int SETTLE = 20;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmdStart = 1'b0;
    logic cmdReadBack = 1'b0;
    logic [7:0] cmdData = 8'h00;
    logic delayIn = 1'b0;
    logic cmdReady, cmdDone, delayOut, codeSettled;
    logic [7:0] rdData, activeCode, activeCodeB, got;
    int n_fail = 0;
    int tests_run = 0;
    int d0, dMid, dMax;
    sdcl_if link ();
    sdcl_if linkB ();
    always #2.5 sys_clk = ~sys_clk;
    // Ends under test and checker
    sdcl_host u_sdcl_host (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link),
        .cmdStart(cmdStart), .cmdReadBack(cmdReadBack), .cmdData(cmdData),
        .cmdReady(cmdReady), .cmdDone(cmdDone), .rdData(rdData));
    sdcl_device #(.SETTLE_CYCLES(SETTLE)) u_sdcl_device (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .link(link), .delayIn(delayIn), .delayOut(delayOut),
        .activeCode(activeCode), .codeSettled(codeSettled));
    sdcl_device #(.SETTLE_CYCLES(SETTLE)) u_sdcl_device_b (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .link(linkB), .delayIn(1'b0), .delayOut(),
        .activeCode(activeCodeB), .codeSettled());
    sdcl_check_sva u_sdcl_check_sva (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .enable(link.enable), .sclk(link.sclk), .sdi(link.sdi), .sdo(link.sdo),
        .sdoEn(link.sdoEn));
    // Compare and count
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test
    // One host transfer, bounded wait for done
    task automatic host_cmd(input logic rb, input logic [7:0] data);
        int k;
        cmdReadBack = rb;
        cmdData = data;
        cmdStart = 1'b1;
        @(negedge sys_clk);
        cmdStart = 1'b0;
        for (k = 0; k < 2000 && cmdDone !== 1'b1; k++) @(negedge sys_clk);
        if (k == 2000) begin
            chk("host done", 8'h01, 8'h00);
            finish_test();
        end
    endtask : host_cmd
    // Pulse train in, cycles to first output rise
    task automatic measure(output int d);
        repeat (SETTLE + 4) @(negedge sys_clk);
        delayIn = 1'b1;
        for (d = 0; d < 400 && delayOut !== 1'b1; d++) begin
            @(negedge sys_clk);
            delayIn = ~d[2];
        end
        delayIn = 1'b0;
        repeat (300) @(negedge sys_clk);
    endtask : measure
    // Raw frame on second link, 125 ns clock
    task automatic raw_frame(input logic en, input logic [7:0] code, output logic [7:0] q);
        linkB.enable = en;
        repeat (16) @(negedge sys_clk);
        for (int b = 7; b >= 0; b--) begin
            q[b] = linkB.qLine;
            linkB.sdi = code[b];
            repeat (13) @(negedge sys_clk);
            linkB.sclk = 1'b1;
            repeat (12) @(negedge sys_clk);
            linkB.sclk = 1'b0;
        end
        repeat (12) @(negedge sys_clk);
        linkB.enable = 1'b0;
        linkB.sdi = ~linkB.sdi;
        repeat (12) @(negedge sys_clk);
    endtask : raw_frame
    // Main sequence
    initial begin
        linkB.enable = 1'b0;
        linkB.sclk = 1'b0;
        linkB.sdi = 1'b0;
        repeat (5) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk("reset code", 8'h00, activeCode);
        host_cmd(1'b0, 8'ha5);
        chk("code", 8'ha5, activeCode);
        chk("settling", 8'h00, {7'h00, codeSettled});
        repeat (SETTLE + 4) @(negedge sys_clk);
        chk("settled", 8'h01, {7'h00, codeSettled});
        host_cmd(1'b0, 8'h3c);
        chk("shifted out", 8'ha5, rdData);
        host_cmd(1'b1, 8'h00);
        chk("readback", 8'h3c, rdData);
        chk("code kept", 8'h3c, activeCode);
        $display("test link done");
        host_cmd(1'b0, 8'h00);
        measure(d0);
        host_cmd(1'b0, 8'h80);
        measure(dMid);
        host_cmd(1'b0, 8'hff);
        measure(dMax);
        chk("mid step", 8'h80, 8'(dMid - d0));
        chk("full span", 8'hff, 8'(dMax - d0));
        $display("test delay done");
        raw_frame(1'b1, 8'h5a, got);
        chk("frame code", 8'h5a, activeCodeB);
        raw_frame(1'b0, 8'h00, got);
        chk("idle line", 8'hff, got);
        chk("ignored", 8'h5a, activeCodeB);
        raw_frame(1'b1, 8'hff, got);
        chk("old out", 8'h5a, got);
        chk("destroyed", 8'hff, activeCodeB);
        $display("test fault frames done");
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
